// [iwd_params.svh]
// Purpose: Constants for the 14-bit instruction word decoder
// Assumes: Core clock ref_clk at 20 MHz
// Notes:   Field positions, class codes and timing counts
`ifndef IWD_PARAMS_SVH
`define IWD_PARAMS_SVH

// Word layout
`define IWD_WORD_W        14
`define IWD_CLASS_HI      13
`define IWD_CLASS_LO      12
`define IWD_BYTE_OP_HI    13
`define IWD_BYTE_OP_LO    8
`define IWD_DEST_BIT      7
`define IWD_FILE_HI       6
`define IWD_FILE_LO       0
`define IWD_BIT_OP_HI     13
`define IWD_BIT_OP_LO     10
`define IWD_BITNUM_HI     9
`define IWD_BITNUM_LO     7
`define IWD_LIT8_HI       7
`define IWD_LIT11_HI      10
`define IWD_JMP_OP_LO     11
`define IWD_SUB_HI        11
`define IWD_SUB_LO        10

// Class codes in bits 13:12
`define IWD_CLS_BYTE      2'h0
`define IWD_CLS_BIT       2'h1
`define IWD_CLS_JUMP      2'h2
`define IWD_CLS_LIT       2'h3

// Bit-class sub-opcodes in bits 11:10
`define IWD_SUB_SKIP_CLR  2'h2
`define IWD_SUB_SKIP_SET  2'h3

// Fixed control words
`define IWD_W_STANDBY     14'h0063
`define IWD_W_RETURN      14'h0008
`define IWD_W_RETFIE      14'h0009
`define IWD_W_WDOG_CLR    14'h0064

// Byte-class opcodes that skip (decrement/increment and skip on zero)
`define IWD_OP_DECSZ      6'h0b
`define IWD_OP_INCSZ      6'h0f
// Literal-class return with literal: bits 13:10 = 1101
`define IWD_OP_RETLIT     4'hd

// Oscillator periods per instruction cycle
`define IWD_OSC_PER_CYC   4
`define IWD_PHASE_W       2

`endif

// [iwd_pkg.sv]
// Purpose: Types for the instruction word decoder
// Assumes: Used together with iwd_params.svh
// Notes:   Types only; numbers live in the header
package iwd_pkg;

    typedef enum logic [1:0] {
        IWD_CLS_BYTE_E = 2'h0,
        IWD_CLS_BIT_E  = 2'h1,
        IWD_CLS_JUMP_E = 2'h2,
        IWD_CLS_LIT_E  = 2'h3
    } iwd_class_t;

    typedef enum logic [1:0] {
        IWD_ST_IDLE  = 2'h0,
        IWD_ST_EXEC  = 2'h1,
        IWD_ST_FLUSH = 2'h2
    } iwd_state_t;

endpackage

// [iwd_phase.sv]
// Purpose: Quarter-phase counter making one instruction cycle of four clocks
// Assumes: ref_clk stands for the oscillator period
// Notes:   cyc_end pulses on the last of the four periods
`timescale 1ns/100ps
`include "iwd_params.svh"

module iwd_phase (
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    // Phase outputs
    output logic [`IWD_PHASE_W-1:0]       phase,
    output logic                          cyc_end
);

    typedef struct packed {
        logic [`IWD_PHASE_W-1:0] cnt;
    } iwd_ph_st_t;

    iwd_ph_st_t s_q;
    iwd_ph_st_t s_d;

    // Free-running count, wraps every instruction cycle
    always_comb begin
        s_d     = s_q;
        s_d.cnt = s_q.cnt + `IWD_PHASE_W'(1);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign phase   = s_q.cnt;
    assign cyc_end = (s_q.cnt == `IWD_PHASE_W'(`IWD_OSC_PER_CYC - 1));

    // Cycle end recurs every four periods
    a_phase_period: assert property (@(posedge ref_clk) disable iff (rst)
        cyc_end |=> !cyc_end [*3] ##1 cyc_end)
        else $error("instruction cycle is not four periods");

endmodule

// [iwd_decoder.sv]
// Purpose: Decode 14-bit instruction words into fields and cycle timing
// Assumes: Fetch path offers one word per instruction cycle, all on ref_clk
// Notes:   Outputs other than cycle_start are registered at the end of each instruction cycle
`timescale 1ns/100ps
`include "iwd_params.svh"

// Functional notes
// - Take one 14-bit word, split opcode/operands
// - Byte ops: opcode 13:8, dest 7, file 6:0
// - Dest zero targets accumulator, one targets register
// - File address spans 0x00 to 0x7F
// - Bit ops: opcode 13:10, bit 9:7, file
// - Literal 8 bits; jump/call opcode 13:11, 11-bit constant
// - Don't-care bits never change decoding
// - One cycle; taken skip/branch adds no-op cycle
// - Instruction cycle equals four oscillator periods
// - Bit test skip clear 10, set 11
// - Recognise standby word, flag status effect
module iwd_decoder (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    // Fetch side
    input  wire logic [`IWD_WORD_W-1:0]    instr_word,
    input  wire logic                      instr_valid,
    // Datapath condition for skips (test true)
    input  wire logic                      cond_true,
    // Decoded fields
    output logic [1:0]                     instr_class,
    output logic [5:0]                     opcode,
    output logic                           dest_to_reg,
    output logic                           dest_to_acc,
    output logic [6:0]                     file_addr,
    output logic [2:0]                     bit_sel,
    output logic [7:0]                     lit8,
    output logic [10:0]                    lit11,
    // Decoded events
    output logic                           bit_test_skip_clear,
    output logic                           bit_test_skip_set,
    output logic                           is_standby,
    output logic                           status_touch,
    output logic                           changes_program_counter,
    // Timing
    output logic                           cycle_start,
    output logic                           exec_nop,
    output logic                           busy_two_cycle
);

    typedef struct packed {
        iwd_pkg::iwd_state_t st;
        logic [1:0]          cls;
        logic [5:0]          op;
        logic                dreg;
        logic [6:0]          faddr;
        logic [2:0]          bsel;
        logic [7:0]          l8;
        logic [10:0]         l11;
        logic                skc;
        logic                sks;
        logic                stby;
        logic                stat;
        logic                pcchg;
        logic                nop;
    } iwd_dec_st_t;

    iwd_dec_st_t s_q;
    iwd_dec_st_t s_d;

    logic [`IWD_PHASE_W-1:0] phase;
    logic                    cyc_end;

    // four-period instruction cycle
    // Instruction cycle timing
    iwd_phase u_phase (
        .ref_clk (ref_clk),
        .rst     (rst),
        .phase   (phase),
        .cyc_end (cyc_end)
    );

    // Does this word rewrite the program counter
    function automatic logic pc_write(input logic [`IWD_WORD_W-1:0] w);
        logic r;
        r = 1'b0;
        if (w[`IWD_CLASS_HI:`IWD_CLASS_LO] == `IWD_CLS_JUMP) begin
            r = 1'b1;
        end else if (w == `IWD_W_RETURN || w == `IWD_W_RETFIE) begin
            r = 1'b1;
        end else if (w[`IWD_CLASS_HI:`IWD_CLASS_LO] == `IWD_CLS_LIT
                     && w[13:10] == `IWD_OP_RETLIT) begin
            r = 1'b1;
        end else if (w[`IWD_CLASS_HI:`IWD_CLASS_LO] == `IWD_CLS_BYTE
                     && w[7] && w[6:0] == 7'h02) begin
            r = 1'b1; // Writing the counter's low byte register
        end
        return r;
    endfunction

    // Does this word hold a conditional skip
    function automatic logic is_skip(input logic [`IWD_WORD_W-1:0] w);
        logic r;
        r = 1'b0;
        if (w[`IWD_CLASS_HI:`IWD_CLASS_LO] == `IWD_CLS_BIT
            && w[`IWD_SUB_HI]) begin
            r = 1'b1;
        end else if (w[`IWD_CLASS_HI:`IWD_CLASS_LO] == `IWD_CLS_BYTE
                     && (w[13:8] == `IWD_OP_DECSZ || w[13:8] == `IWD_OP_INCSZ)) begin
            r = 1'b1;
        end
        return r;
    endfunction

    // Next-state decode, taken once per instruction cycle
    always_comb begin
        s_d = s_q;
        if (cyc_end) begin
            s_d.nop = 1'b0;
            if (s_q.st == iwd_pkg::IWD_ST_EXEC && (s_q.pcchg
                || ((s_q.skc || s_q.sks || s_q.op == `IWD_OP_DECSZ
                     || s_q.op == `IWD_OP_INCSZ) && s_q.cls != `IWD_CLS_LIT
                    && s_q.cls != `IWD_CLS_JUMP && cond_true
                    && (s_q.cls == `IWD_CLS_BIT || s_q.op[5:4] == 2'h0)))) begin
                s_d.st    = iwd_pkg::IWD_ST_FLUSH;
                s_d.nop   = 1'b1;
                s_d.skc   = 1'b0;
                s_d.sks   = 1'b0;
                s_d.stby  = 1'b0;
                s_d.stat  = 1'b0;
                s_d.pcchg = 1'b0;
            end else if (instr_valid) begin
                s_d.st = iwd_pkg::IWD_ST_EXEC;
                s_d.cls = instr_word[`IWD_CLASS_HI:`IWD_CLASS_LO];
                s_d.op = instr_word[`IWD_BYTE_OP_HI:`IWD_BYTE_OP_LO];
                s_d.dreg = instr_word[`IWD_DEST_BIT];
                s_d.faddr = instr_word[`IWD_FILE_HI:`IWD_FILE_LO];
                s_d.bsel = instr_word[`IWD_BITNUM_HI:`IWD_BITNUM_LO];
                s_d.l8  = instr_word[`IWD_LIT8_HI:0];
                s_d.l11 = instr_word[`IWD_LIT11_HI:0];
                if (instr_word[`IWD_CLASS_HI:`IWD_CLASS_LO] == `IWD_CLS_JUMP) begin
                    s_d.op = {3'h0, instr_word[`IWD_BYTE_OP_HI:`IWD_JMP_OP_LO]};
                end else if (instr_word[`IWD_CLASS_HI:`IWD_CLASS_LO] == `IWD_CLS_BIT) begin
                    s_d.op = {2'h0, instr_word[`IWD_BIT_OP_HI:`IWD_BIT_OP_LO]};
                end else if (instr_word[`IWD_CLASS_HI:`IWD_CLASS_LO] == `IWD_CLS_LIT) begin
                    s_d.op = instr_word[`IWD_BYTE_OP_HI:`IWD_BYTE_OP_LO];
                    if (!instr_word[`IWD_SUB_HI]) begin
                        s_d.op[1:0] = 2'h0; // Move and return forms: bits 9:8 free
                    end else if (instr_word[`IWD_SUB_LO]) begin
                        s_d.op[0] = 1'b0; // Add/subtract forms: bit 8 free
                    end
                end
                s_d.skc = instr_word[`IWD_CLASS_HI:`IWD_CLASS_LO] == `IWD_CLS_BIT
                          && instr_word[`IWD_SUB_HI:`IWD_SUB_LO] == `IWD_SUB_SKIP_CLR;
                s_d.sks = instr_word[`IWD_CLASS_HI:`IWD_CLASS_LO] == `IWD_CLS_BIT
                          && instr_word[`IWD_SUB_HI:`IWD_SUB_LO] == `IWD_SUB_SKIP_SET;
                s_d.stby  = instr_word == `IWD_W_STANDBY;
                s_d.stat  = instr_word == `IWD_W_STANDBY || instr_word == `IWD_W_WDOG_CLR;
                s_d.pcchg = pc_write(instr_word);
                if (!is_skip(instr_word)) begin
                    s_d.skc = 1'b0;
                end
            end else begin
                s_d.st    = iwd_pkg::IWD_ST_IDLE;
                s_d.skc   = 1'b0;
                s_d.sks   = 1'b0;
                s_d.stby  = 1'b0;
                s_d.stat  = 1'b0;
                s_d.pcchg = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Registered field outputs
    assign instr_class             = s_q.cls;
    assign opcode                  = s_q.op;
    assign dest_to_reg             = s_q.dreg && s_q.cls == `IWD_CLS_BYTE;
    assign dest_to_acc             = !s_q.dreg && s_q.cls == `IWD_CLS_BYTE;
    assign file_addr               = s_q.faddr;
    assign bit_sel                 = s_q.bsel;
    assign lit8                    = s_q.l8;
    assign lit11                   = s_q.l11;
    assign bit_test_skip_clear     = s_q.skc;
    assign bit_test_skip_set       = s_q.sks;
    assign is_standby              = s_q.stby;
    assign status_touch            = s_q.stat;
    assign changes_program_counter = s_q.pcchg;
    assign exec_nop                = s_q.nop;
    assign busy_two_cycle          = s_q.st == iwd_pkg::IWD_ST_FLUSH;
    assign cycle_start             = phase == `IWD_PHASE_W'(0);

    sequence s_jump_taken;
        cyc_end && instr_valid && s_d.st == iwd_pkg::IWD_ST_EXEC
            && instr_word[13:12] == 2'h2;
    endsequence

    // Flush shows one clock after the next cycle end and stands four clocks
    sequence s_flush_cycle;
        ##5 exec_nop [*4];
    endsequence

    // Checks
    a_class_field: assert property (@(posedge ref_clk) disable iff (rst)
        cyc_end && instr_valid && s_d.st == iwd_pkg::IWD_ST_EXEC
        |=> instr_class == $past(instr_word[13:12]))
        else $error("class not taken from bits 13:12");
    a_file_addr: assert property (@(posedge ref_clk) disable iff (rst)
        cyc_end && instr_valid && s_d.st == iwd_pkg::IWD_ST_EXEC
        |=> file_addr == $past(instr_word[6:0]) && bit_sel == $past(instr_word[9:7]))
        else $error("file or bit field wrong");
    a_dest_sel: assert property (@(posedge ref_clk) disable iff (rst)
        cyc_end && instr_valid && s_d.st == iwd_pkg::IWD_ST_EXEC && instr_word[13:12] == 2'h0
        |=> dest_to_reg == $past(instr_word[7]) && dest_to_acc != dest_to_reg)
        else $error("destination select wrong");
    a_lit_fields: assert property (@(posedge ref_clk) disable iff (rst)
        cyc_end && instr_valid && s_d.st == iwd_pkg::IWD_ST_EXEC
        |=> lit11 == $past(instr_word[10:0]) && lit8 == lit11[7:0])
        else $error("literal field wrong");
    a_jump_flush: assert property (@(posedge ref_clk) disable iff (rst)
        s_jump_taken |-> s_flush_cycle)
        else $error("jump without no-op cycle");
    a_skip_kind: assert property (@(posedge ref_clk) disable iff (rst)
        bit_test_skip_set |-> instr_class == 2'h1 && opcode[1:0] == 2'h3 && !bit_test_skip_clear)
        else $error("skip-if-set decode wrong");
    a_standby_word: assert property (@(posedge ref_clk) disable iff (rst)
        cyc_end && instr_valid && s_d.st == iwd_pkg::IWD_ST_EXEC && instr_word == 14'h0063
        |=> is_standby && status_touch)
        else $error("standby word missed");
    a_nop_length: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(exec_nop) |-> exec_nop [*4] ##1 !exec_nop)
        else $error("no-op cycle not four periods");

endmodule

// [iwd_testbench.sv]
// Purpose: Self-checking bench for the 14-bit instruction word decoder
// Assumes: Inputs change by non-blocking assignment on the rising edge of ref_clk
// Notes:   After each run, outputs are judged at the falling edge while phase is 0
`timescale 1ns/100ps
`include "iwd_params.svh"

module testbench;
    // Skip table: word and condition; the condition also says whether a flush cycle must follow
    localparam logic [13:0] SKIP_W [5] = '{14'h1835, 14'h1c35, 14'h1c35, 14'h0b90, 14'h0f90};
    localparam logic        SKIP_C [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    localparam logic [13:0] JMP_W  [4] = '{14'h2805, 14'h27ff, 14'h0008, 14'h34a5};

    // Stimulus and observed outputs
    logic        ref_clk;
    logic        rst;
    logic [13:0] instr_word;
    logic        instr_valid;
    logic        cond_true;
    logic [1:0]  instr_class;
    logic [5:0]  opcode;
    logic        dest_to_reg;
    logic        dest_to_acc;
    logic [6:0]  file_addr;
    logic [2:0]  bit_sel;
    logic [7:0]  lit8;
    logic [10:0] lit11;
    logic        bit_test_skip_clear;
    logic        bit_test_skip_set;
    logic        is_standby;
    logic        status_touch;
    logic        changes_program_counter;
    logic        cycle_start;
    logic        exec_nop;
    logic        busy_two_cycle;
    int          fails;
    int          n_tests;

    iwd_decoder dut (
        .ref_clk(ref_clk), .rst(rst), .instr_word(instr_word),
        .instr_valid(instr_valid), .cond_true(cond_true),
        .instr_class(instr_class), .opcode(opcode), .dest_to_reg(dest_to_reg),
        .dest_to_acc(dest_to_acc), .file_addr(file_addr), .bit_sel(bit_sel),
        .lit8(lit8), .lit11(lit11), .bit_test_skip_clear(bit_test_skip_clear),
        .bit_test_skip_set(bit_test_skip_set), .is_standby(is_standby),
        .status_touch(status_touch), .changes_program_counter(changes_program_counter),
        .cycle_start(cycle_start), .exec_nop(exec_nop), .busy_two_cycle(busy_two_cycle)
    );

    // Clock of 50 ns period
    always #25 ref_clk = ~ref_clk;

    // Compare one value and count the outcome
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hold one word for a whole instruction cycle; ends back at phase 0
    task automatic run(input logic [13:0] w, input logic v, input logic c);
        @(posedge ref_clk);
        instr_word  <= w;
        instr_valid <= v;
        cond_true   <= c;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // Byte class at both ends of the file range and both destinations
    task automatic t_byte;
        for (int i = 0; i < 4; i++) begin
            run({2'b00, 4'h7, i[0], (i[1] ? 7'h7f : 7'h00)}, 1'b1, 1'b0);
            chk("class", instr_class, 2'h0);
            chk("opcode", opcode, 6'h07);
            chk("dest_to_reg", dest_to_reg, i[0]);
            chk("dest_to_acc", dest_to_acc, !i[0]);
            chk("file_addr", file_addr, (i[1] ? 7'h7f : 7'h00));
        end
        $display("test byte done");
    endtask

    // Every bit-class sub-opcode with every bit number
    task automatic t_bit;
        logic [13:0] w;
        for (int s = 0; s < 4; s++) begin
            for (int b = 0; b < 8; b++) begin
                w = {2'b01, s[1:0], b[2:0], 7'h35};
                run(w, 1'b1, 1'b0);
                chk("class", instr_class, 2'h1);
                chk("opcode", opcode, {2'b00, w[13:10]});
                chk("bit_sel", bit_sel, b[2:0]);
                chk("file_addr", file_addr, 7'h35);
                chk("skip_clear", bit_test_skip_clear, s == 2);
                chk("skip_set", bit_test_skip_set, s == 3);
            end
        end
        $display("test bit done");
    endtask

    // Literal add and move with their don't-care bits at both values
    task automatic t_literal;
        for (int x = 0; x < 2; x++) begin
            run(14'h3e5a | {5'h00, x[0], 8'h00}, 1'b1, 1'b0);
            chk("class", instr_class, 2'h3);
            chk("opcode", opcode, 6'h3e);
            chk("lit8", lit8, 8'h5a);
            chk("pc_change", changes_program_counter, 1'b0);
            run(14'h30a5 | {4'h0, x[0], x[0], 8'h00}, 1'b1, 1'b0);
            chk("opcode", opcode, 6'h30);
        end
        run(14'h39a5, 1'b1, 1'b0);
        chk("opcode", opcode, 6'h39);
        $display("test literal done");
    endtask

    // Standby and watchdog words, then an idle cycle
    task automatic t_standby;
        run(`IWD_W_STANDBY, 1'b1, 1'b0);
        chk("is_standby", is_standby, 1'b1);
        chk("status_touch", status_touch, 1'b1);
        run(`IWD_W_WDOG_CLR, 1'b1, 1'b0);
        chk("is_standby", is_standby, 1'b0);
        run(14'h0063, 1'b0, 1'b0);
        chk("is_standby", is_standby, 1'b0);
        chk("lit8", lit8, 8'h64);
        $display("test standby done");
    endtask

    // Counter-changing words each followed by a flush that ignores its word
    task automatic t_jump;
        for (int i = 0; i < 4; i++) begin
            run(JMP_W[i], 1'b1, 1'b0);
            chk("exec_nop", exec_nop, 1'b0);
            chk("pc_change", changes_program_counter, 1'b1);
            if (i < 2) begin
                chk("class", instr_class, 2'h2);
                chk("opcode", opcode, {3'b000, JMP_W[i][13:11]});
                chk("lit11", lit11, JMP_W[i][10:0]);
            end
            run(14'h3fff, 1'b1, 1'b0);
            chk("exec_nop", exec_nop, 1'b1);
            chk("busy", busy_two_cycle, 1'b1);
            chk("lit11_hold", lit11, JMP_W[i][10:0]);
        end
        $display("test jump done");
    endtask

    // Skips flush only when the condition is true
    task automatic t_skip;
        for (int i = 0; i < 5; i++) begin
            run(SKIP_W[i], 1'b1, 1'b0);
            run(14'h0000, 1'b1, SKIP_C[i]);
            chk("exec_nop", exec_nop, SKIP_C[i]);
            chk("busy", busy_two_cycle, SKIP_C[i]);
            run(14'h0000, 1'b1, 1'b0);
            chk("exec_nop", exec_nop, 1'b0);
        end
        $display("test skip done");
    endtask

    // Cycle start marks one clock in every four
    task automatic t_timing;
        for (int i = 0; i < 12; i++) begin
            chk("cycle_start", cycle_start, (i % 4) == 0);
            @(negedge ref_clk);
        end
        $display("test timing done");
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        close_out();
    end

    // Main sequence
    initial begin
        ref_clk     = 1'b0;
        rst         = 1'b1;
        instr_word  = 14'h0000;
        instr_valid = 1'b0;
        cond_true   = 1'b0;
        fails       = 0;
        n_tests     = 0;
        repeat (4) @(posedge ref_clk);
        #1;
        chk("reset_start", cycle_start, 1'b1);
        chk("reset_nop", exec_nop, 1'b0);
        @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        t_byte();
        t_bit();
        t_literal();
        t_standby();
        t_jump();
        t_skip();
        t_timing();
        close_out();
    end
endmodule
